// ==== rtl/ldcs_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// config and status register slice
// ============================================================
// Operation
// - current codes 8-bit, 0.1 mA steps
// - green and blue current reset to af
// - setup bit 6 selects fast dimming clock
// - setup bit 5 allows low power mode
// - setup bits 4:3 select pump gain
// - setup bit 2 routes red supply direct
// - setup bits 1:0 pick controller clock source
// - step pointers are 4-bit read/write values
// - pointer writes resync to slow clock
// - pointer access only while channel held
// - status bit 3 shows outside clock active
// - status bits 2:0 are channel event flags
// - status read clears all event flags
// - interrupt pin releases after status read
// - hold run state code 00 only
module ldcs_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] red_run_control_state,
    input wire logic [1:0] green_run_control_state,
    input wire logic [1:0] blue_run_control_state,
    input wire logic [2:0] channel_event,
    input wire logic outside_clock_active,
    input wire logic external_slow_clock,
    output logic [7:0] green_current_code,
    output logic [7:0] blue_current_code,
    output logic fast_dimming_clock_sel,
    output logic low_power_allow,
    output logic [1:0] pump_gain_select,
    output logic red_supply_direct,
    output logic clock_detect_allow,
    output logic [1:0] clock_source_sel,
    output logic [3:0] red_step_pointer,
    output logic [3:0] green_step_pointer,
    output logic [3:0] blue_step_pointer,
    output logic [2:0] pointer_load,
    output logic int_n
);
    // ============================================================
    // input synchronisers
    // ============================================================
    // the slow clock pin and the outside clock flag come from another
    // domain, so each passes two stages that nothing else reads and a
    // third stage that feeds the logic. the slow clock keeps one more
    // stage of history so that its rising edge is found between two
    // settled copies. neither chain is reset: the pending bits are clear
    // in reset, so an unknown edge early on has nothing to act upon.
    logic slow_meta_r; // slow clock stage one
    logic [2:0] slow_sync_r; // slow clock stages two and three, history
    logic [1:0] ext_meta_r; // outside clock flag stages one and two
    logic ext_sync_r; // outside clock flag stage three
    logic slow_rise; // slow clock rising edge
    // ============================================================
    // register state
    // ============================================================
    logic [7:0] green_cur_r, green_cur_nxt; // green current code
    logic [7:0] blue_cur_r, blue_cur_nxt; // blue current code
    logic [7:0] setup_r, setup_nxt; // setup bits
    logic [3:0] ptr_r [ldcs_pkg::NUM_CH]; // host pointer values
    logic [3:0] ptr_nxt [ldcs_pkg::NUM_CH];
    logic [3:0] act_r [ldcs_pkg::NUM_CH]; // pointers in effect
    logic [3:0] act_nxt [ldcs_pkg::NUM_CH];
    logic [2:0] pend_r, pend_nxt; // pointer write awaiting slow edge
    logic [2:0] load_r, load_nxt; // pointer load strobe
    logic [2:0] flag_r, flag_nxt; // channel event flags
    logic [7:0] rdata_r, rdata_nxt; // read data
    logic [2:0] held; // channel in hold state
    logic [1:0] run_state [ldcs_pkg::NUM_CH];

    assign run_state[0] = blue_run_control_state;
    assign run_state[1] = green_run_control_state;
    assign run_state[2] = red_run_control_state;
    assign slow_rise = slow_sync_r[1] & ~slow_sync_r[2];

    // hold decode per channel, index 2 red, 1 green, 0 blue
    genvar gi;
    generate
        for (gi = 0; gi < ldcs_pkg::NUM_CH; gi++) begin : g_hold
            assign held[gi] = (run_state[gi] == ldcs_pkg::RUN_HOLD);
        end
    endgenerate

    // pointer address by channel index
    function automatic logic [7:0] ptr_addr(input int ch);
        ptr_addr = ldcs_pkg::ADDR_BLUE_PC - 8'(ch);
    endfunction

    // ============================================================
    // next-state logic
    // ============================================================
    // every register but the load strobe keeps its value unless a host
    // strobe, a channel event or a slow clock edge changes it. the host
    // port takes one access per strobe:
    // a write lands at the edge that samples reg_wr, a read presents
    // its data one edge after reg_rd and holds it until the next read.
    //
    // pointer writes go through two steps. the host value is stored at
    // once, so a read straight after shows what was written; the copy in
    // effect only moves at the next synced rising edge of the slow clock,
    // and a one-cycle load pulse marks that moment for the channel.
    // a second write before that edge replaces the pending value; the
    // host is expected to keep pointer writes far apart.
    //
    // a channel not in hold neither takes a pointer write nor shows its
    // pointer on a read: the write is dropped and the read returns zero.
    // unused bits of every register read as zero and take no writes.
    //
    // next values for every register but the event flags
    always_comb begin
        green_cur_nxt = green_cur_r;
        blue_cur_nxt = blue_cur_r;
        setup_nxt = setup_r;
        pend_nxt = pend_r;
        load_nxt = 3'h0;
        rdata_nxt = rdata_r;
        for (int c = 0; c < ldcs_pkg::NUM_CH; c++) begin
            ptr_nxt[c] = ptr_r[c];
            act_nxt[c] = act_r[c];
        end
        // host writes
        if (reg_wr) begin
            unique case (reg_addr)
                ldcs_pkg::ADDR_GREEN_CUR: green_cur_nxt = reg_wdata;
                ldcs_pkg::ADDR_BLUE_CUR: blue_cur_nxt = reg_wdata;
                ldcs_pkg::ADDR_SETUP: begin
                    setup_nxt = reg_wdata & ldcs_pkg::SETUP_MASK;
                end
                default: begin
                end
            endcase
            for (int c = 0; c < ldcs_pkg::NUM_CH; c++) begin
                // accepted only while held; bits above 3 dropped
                if (reg_addr == ptr_addr(c) && held[c]) begin
                    ptr_nxt[c] = reg_wdata[3:0];
                    pend_nxt[c] = 1'b1;
                end
            end
        end
        // transfer pending pointers on slow clock edge
        for (int c = 0; c < ldcs_pkg::NUM_CH; c++) begin
            if (pend_r[c] && slow_rise) begin
                act_nxt[c] = ptr_r[c];
                pend_nxt[c] = 1'b0;
                load_nxt[c] = 1'b1;
            end
        end
        // host reads
        if (reg_rd) begin
            rdata_nxt = 8'h00;
            unique case (reg_addr)
                ldcs_pkg::ADDR_GREEN_CUR: rdata_nxt = green_cur_r;
                ldcs_pkg::ADDR_BLUE_CUR: rdata_nxt = blue_cur_r;
                ldcs_pkg::ADDR_SETUP: rdata_nxt = setup_r;
                ldcs_pkg::ADDR_STATUS: begin
                    rdata_nxt[ldcs_pkg::STAT_OUTSIDE_CLK] = ext_sync_r;
                    rdata_nxt[2:0] = flag_r;
                end
                default: begin
                end
            endcase
            for (int c = 0; c < ldcs_pkg::NUM_CH; c++) begin
                // held channel only; otherwise zero
                if (reg_addr == ptr_addr(c) && held[c]) begin
                    rdata_nxt = {4'h0, ptr_r[c]};
                end
            end
        end
    end

    // ============================================================
    // channel event flags
    // ============================================================
    // a flag is set by a one-cycle event pulse from its channel and
    // stays set until the host reads the status register. when an event
    // and a clearing read fall in one cycle the event is kept, so the
    // host never loses a notification: the read shows the old flags and
    // the pin stays low for the new one.
    //
    // event flags: status read clears, new event wins
    always_comb begin
        flag_nxt = flag_r;
        if (reg_rd && reg_addr == ldcs_pkg::ADDR_STATUS) begin
            flag_nxt = 3'h0;
        end
        flag_nxt = flag_nxt | channel_event;
    end

    // ============================================================
    // state registers
    // ============================================================
    // synchronous reset, active high. the synchronisers run on through
    // reset so that they are flushed by the time it is released; all
    // other state takes its reset value and then only its next value.
    //
    // register everything
    always_ff @(posedge clk) begin
        slow_meta_r <= external_slow_clock;
        slow_sync_r <= {slow_sync_r[1:0], slow_meta_r};
        ext_meta_r <= {ext_meta_r[0], outside_clock_active};
        ext_sync_r <= ext_meta_r[1];
        if (rst) begin
            green_cur_r <= ldcs_pkg::RST_CURRENT;
            blue_cur_r <= ldcs_pkg::RST_CURRENT;
            setup_r <= ldcs_pkg::RST_SETUP;
            pend_r <= 3'h0;
            load_r <= 3'h0;
            flag_r <= 3'h0;
            rdata_r <= 8'h00;
            for (int c = 0; c < ldcs_pkg::NUM_CH; c++) begin
                ptr_r[c] <= ldcs_pkg::RST_PC;
                act_r[c] <= ldcs_pkg::RST_PC;
            end
        end else begin
            green_cur_r <= green_cur_nxt;
            blue_cur_r <= blue_cur_nxt;
            setup_r <= setup_nxt;
            pend_r <= pend_nxt;
            load_r <= load_nxt;
            flag_r <= flag_nxt;
            rdata_r <= rdata_nxt;
            for (int c = 0; c < ldcs_pkg::NUM_CH; c++) begin
                ptr_r[c] <= ptr_nxt[c];
                act_r[c] <= act_nxt[c];
            end
        end
    end

    // ============================================================
    // outputs
    // ============================================================
    // every output comes straight from a register except the interrupt
    // pin, which is a plain nor of the flag registers. the setup fields
    // are slices of one register, so they all change in the same cycle
    // after a setup write. the clock detect enable is the upper bit of
    // the clock source field and moves with it.
    //
    // read data
    assign reg_rdata = rdata_r;
    assign green_current_code = green_cur_r;
    assign blue_current_code = blue_cur_r;
    assign fast_dimming_clock_sel = setup_r[ldcs_pkg::SETUP_FAST_DIM];
    assign low_power_allow = setup_r[ldcs_pkg::SETUP_LOW_PWR];
    assign pump_gain_select =
        setup_r[ldcs_pkg::SETUP_PUMP_HI:ldcs_pkg::SETUP_PUMP_LO];
    assign red_supply_direct = setup_r[ldcs_pkg::SETUP_RED_DIRECT];
    assign clock_source_sel =
        setup_r[ldcs_pkg::SETUP_CLK_HI:ldcs_pkg::SETUP_CLK_LO];
    assign clock_detect_allow = setup_r[ldcs_pkg::SETUP_CLK_HI];
    // pointers in effect, index 2 red, 1 green, 0 blue
    assign red_step_pointer = act_r[2];
    assign green_step_pointer = act_r[1];
    assign blue_step_pointer = act_r[0];
    assign pointer_load = load_r;
    // pin low while any flag stands, high after clearing read
    assign int_n = ~|flag_r;
endmodule
`default_nettype wire

// ==== pkg/ldcs_pkg.sv ====
// ============================================================
// register map and field layout
// ============================================================
package ldcs_pkg;
    // register offsets on the register port
    localparam logic [7:0] ADDR_GREEN_CUR = 8'h06;
    localparam logic [7:0] ADDR_BLUE_CUR = 8'h07;
    localparam logic [7:0] ADDR_SETUP = 8'h08;
    localparam logic [7:0] ADDR_RED_PC = 8'h09;
    localparam logic [7:0] ADDR_GREEN_PC = 8'h0a;
    localparam logic [7:0] ADDR_BLUE_PC = 8'h0b;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    // reset values
    localparam logic [7:0] RST_CURRENT = 8'haf;
    localparam logic [7:0] RST_SETUP = 8'h00;
    localparam logic [3:0] RST_PC = 4'h0;
    // setup field layout
    localparam int SETUP_FAST_DIM = 6;
    localparam int SETUP_LOW_PWR = 5;
    localparam int SETUP_PUMP_HI = 4;
    localparam int SETUP_PUMP_LO = 3;
    localparam int SETUP_RED_DIRECT = 2;
    localparam int SETUP_CLK_HI = 1;
    localparam int SETUP_CLK_LO = 0;
    localparam logic [7:0] SETUP_MASK = 8'h7f;
    // status field layout, pointer width and channel count
    localparam int STAT_OUTSIDE_CLK = 3;
    localparam int PC_WIDTH = 4;
    localparam int NUM_CH = 3;
    // run control hold code
    localparam logic [1:0] RUN_HOLD = 2'h0;
    // pump and clock source codes
    localparam logic [1:0] PUMP_OFF = 2'h0;
    localparam logic [1:0] PUMP_BYPASS = 2'h1;
    localparam logic [1:0] PUMP_X15 = 2'h2;
    localparam logic [1:0] PUMP_AUTO = 2'h3;
    localparam logic [1:0] CLKSRC_EXT = 2'h0;
    localparam logic [1:0] CLKSRC_AUTO = 2'h2;
endpackage

// ==== test/ldcs_regs_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====================
// port checker
module ldcs_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [2:0] channel_event,
    input wire logic [7:0] green_current_code,
    input wire logic [1:0] pump_gain_select,
    input wire logic [1:0] clock_source_sel,
    input wire logic [3:0] green_step_pointer,
    input wire logic [2:0] pointer_load,
    input wire logic int_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // status read strobe
    wire logic st_rd = reg_rd && reg_addr == 8'h0c;
    chk_rst_current: assert property (disable iff (1'b0) rst |=>
        green_current_code == 8'haf && int_n) else $error("reset value");
    chk_event_int: assert property (|channel_event |=> !int_n)
        else $error("event left int_n high");
    chk_flag_hold: assert property (!int_n && !st_rd |=> !int_n)
        else $error("flag lost without read");
    chk_read_clears: assert property (st_rd && !channel_event |=> int_n)
        else $error("read left int_n low");
    chk_stat_upper: assert property (st_rd |=> reg_rdata[7:4] == 4'h0)
        else $error("status upper bits");
    chk_unmapped_rd: assert property (reg_rd && reg_addr > 8'h0c |=>
        reg_rdata == 8'h00) else $error("unmapped read");
    chk_setup_wr: assert property (reg_wr && reg_addr == 8'h08 |=>
        pump_gain_select == $past(reg_wdata[4:3]) &&
        clock_source_sel == $past(reg_wdata[1:0])) else $error("setup write");
    chk_current_wr: assert property (reg_wr && reg_addr == 8'h06 |=>
        green_current_code == $past(reg_wdata)) else $error("current write");
    chk_ptr_load: assert property ($changed(green_step_pointer) |->
        pointer_load != 3'h0) else $error("pointer moved without load");
    cov_status_read: cover property (!int_n ##1 st_rd);
    cov_ptr_load: cover property (|pointer_load);
    cov_setup_wr: cover property (reg_wr && reg_addr == 8'h08);
endmodule
bind ldcs_regs ldcs_chk i_ldcs_chk (.clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .channel_event, .green_current_code,
    .pump_gain_select, .clock_source_sel, .green_step_pointer, .pointer_load,
    .int_n);
`default_nettype wire

// ==== test/ldcs_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====================
// host on the register port
module ldcs_host (
    input wire logic clk,
    output logic [7:0] reg_addr = 8'h00,
    output logic [7:0] reg_wdata = 8'h00,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0
);
    // one strobe; caller spaces and holds pointer access
    task automatic xfer(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge clk);
        // strobes drop; released address and data show inverted values
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b00, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// ==== test/tb_ldcs_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====================
// bench for the register slice
module tb_ldcs_regs;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic external_slow_clock = 1'b0;
    logic outside_clock_active = 1'b0;
    logic [2:0] channel_event = 3'h0;
    logic [1:0] green_run_control_state = 2'h0;
    wire logic [7:0] reg_addr, reg_wdata, reg_rdata, green_current_code;
    wire logic reg_wr, reg_rd, int_n;
    wire logic [1:0] pump_gain_select, clock_source_sel;
    wire logic [3:0] red_step_pointer, green_step_pointer, blue_step_pointer;
    wire logic [2:0] pointer_load;
    wire logic [7:0] blue_current_code;
    wire logic fast_dimming_clock_sel, low_power_allow;
    wire logic red_supply_direct, clock_detect_allow;
    wire logic [3:0] sbits = {fast_dimming_clock_sel, low_power_allow,
        red_supply_direct, clock_detect_allow};
    logic [7:0] exp_q [$];
    logic [7:0] v;
    logic [3:0] gv;
    logic rd_d = 1'b0;
    int error_cnt = 0;
    int compares = 0;
    int seed = 22;
    always #12.5 clk = ~clk;
    // 32 kHz pin, each edge lands on a falling edge of clk
    always #15625 external_slow_clock = ~external_slow_clock;
    ldcs_host i_ldcs_host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
    ldcs_regs i_ldcs_regs (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .red_run_control_state(2'h0), .green_run_control_state,
        .blue_run_control_state(2'h0), .channel_event, .outside_clock_active,
        .external_slow_clock, .green_current_code, .blue_current_code,
        .fast_dimming_clock_sel, .low_power_allow, .pump_gain_select,
        .red_supply_direct, .clock_detect_allow, .clock_source_sel,
        .red_step_pointer, .green_step_pointer, .blue_step_pointer,
        .pointer_load, .int_n);
    task automatic check(input string n, input logic [7:0] s, e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp %h seen %h", n, e, s);
        end
    endtask
    // note the expected data, then issue the read
    task automatic rd(input logic [7:0] a, e);
        exp_q.push_back(e);
        i_ldcs_host.xfer(1'b0, a, 8'h00);
    endtask
    task automatic end_of_test();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // read data is settled at the falling edge after the strobe
    always @(posedge clk) rd_d <= reg_rd;
    always @(negedge clk) if (rd_d) check("rd", reg_rdata, exp_q.pop_front());
    initial begin
        #1500000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int a = 6; a < 14; a++) rd(8'(a), a < 8 ? 8'haf : 8'h00);
        i_ldcs_host.xfer(1'b1, 8'h0d, 8'hff);
        rd(8'h0d, 8'h00);
        // every pump and clock code, random other bits
        for (int i = 0; i < 4; i++) begin
            v = ($random(seed) & 8'he4) | 8'(i * 9);
            i_ldcs_host.xfer(1'b1, 8'h06, v);
            i_ldcs_host.xfer(1'b1, 8'h07, ~v);
            i_ldcs_host.xfer(1'b1, 8'h08, v | 8'h80);
            @(negedge clk);
            check("blue", blue_current_code, ~v);
            check("sbits", 8'(sbits), 8'({v[6:5], v[2:1]}));
            check("pump", 8'(pump_gain_select), 8'(i));
            check("clksrc", 8'(clock_source_sel), 8'(i));
            rd(8'h06, v);
            rd(8'h08, v & 8'h7f);
        end
        // pointers take effect on the slow clock
        for (int c = 0; c < 3; c++) begin
            v = $random(seed);
            if (c == 1) gv = v[3:0];
            i_ldcs_host.xfer(1'b1, 8'h09 + 8'(c), v);
            rd(8'h09 + 8'(c), {4'h0, v[3:0]});
            for (int k = 0; k < 1400 && pointer_load == 3'h0; k++) @(negedge clk);
            check("ptr", {4'h0, c == 0 ? red_step_pointer : c == 1 ?
                green_step_pointer : blue_step_pointer}, {4'h0, v[3:0]});
            repeat (6200) @(posedge clk);
        end
        green_run_control_state <= 2'h2;
        i_ldcs_host.xfer(1'b1, 8'h0a, {4'h0, ~gv});
        rd(8'h0a, 8'h00);
        green_run_control_state <= 2'h0;
        rd(8'h0a, {4'h0, gv});
        outside_clock_active <= 1'b1;
        channel_event <= 3'h7;
        @(posedge clk);
        channel_event <= 3'h0;
        repeat (3) @(negedge clk);
        check("int_n", 8'(int_n), 8'h00);
        rd(8'h0c, 8'h0f);
        rd(8'h0c, 8'h08);
        @(negedge clk);
        check("int_n", 8'(int_n), 8'h01);
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(8'h06, 8'haf);
        rd(8'h08, 8'h00);
        repeat (3) @(posedge clk);
        end_of_test();
    end
endmodule
`default_nettype wire
